//--- adc_cal_avg_pkg.sv
// package: register map, field positions and shared types of the calibration/averaging block
`default_nettype none
package adc_cal_avg_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;  // calibration_average_control
  localparam logic [7:0]  OFS_OFFSET    = 8'h04;  // offset_correction_value
  localparam logic [7:0]  TRIG_OFFSET   = 8'h08;  // trigger / activity status
  localparam logic [7:0]  RESULT_OFFSET = 8'h0C;  // last stored result
  localparam logic [7:0]  CALVAL_OFFSET = 8'h10;  // calibration value load flag (bit 0)
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CAL_BIT   = 7;
  localparam int CALIBRATION_FAILED_FLAG_BIT  = 6;
  localparam int CONT_BIT  = 3;
  localparam int AVERAGE_ENABLE_BIT  = 2;
  localparam int TRIG_BIT  = 0;
  localparam int ACT_BIT   = 1;
  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [15:0] OFS_RESET     = 16'h0000;
  localparam int          CAL_CYCLES    = 64;
  localparam int          CONV_CYCLES   = 8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_CAL  = 2'b10
  } state_type;
  typedef struct packed {
    logic        cont;
    logic        avgEn;
    logic [1:0]  avgSel;
  } mode_type;
endpackage : adc_cal_avg_pkg
`default_nettype wire

//--- adc_cal_avg.sv
// design: calibration sequencer, conversion/averaging control and offset correction
//
// Design decisions made here: the APB slave port and the register offsets.
`default_nettype none
// Functional notes
// - setting calibration bit starts self-calibration
// - calibration bit reads one until done
// - register write during calibration fails it
// - calibration start aborts running conversion
// - hardware trigger, write, stop fail calibration
// - any write to failed flag clears it
// - failed flag zero on success, one failure
// - continuous off: one conversion or set
// - continuous on: repeat conversions or sets
// - average enable switches hardware averaging
// - select field gives 4/8/16/32 samples
// - reserved control bits read zero
// - offset is signed left-justified 16-bit
// - offset subtracted before result stored
// - corrected result clamped to mode limits
// - offset written by software or calibration
// - calibration end loads plus-side values
// - active flag spans run, clears on abort
// - trigger select one means hardware trigger
module adc_cal_avg #(
  parameter int DATA_W = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              convStart,
  input  wire logic              sampleValid,
  input  wire logic [DATA_W-1:0] sampleData,
  input  wire logic [DATA_W-1:0] modeMax,
  input  wire logic [DATA_W-1:0] modeMin,
  input  wire logic              stopMode,
  input  wire logic [15:0]       calOffset,
  output logic                   convRequest,
  output logic                   convAbort,
  output logic                   resultValid,
  output logic      [DATA_W-1:0] resultData,
  output logic                   calValueLoad
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  adc_cal_avg_pkg::state_type state_r, state_nxt;
  adc_cal_avg_pkg::mode_type  mode_r;
  logic        cal_r;
  logic        calFail_r;
  logic        trig_r;
  logic [15:0] ofs_r;
  logic [5:0]  calCnt_r;
  logic [5:0]  sampCnt_r;
  logic [20:0] accum_r;
  logic        convRequest_r;
  logic        convAbort_r;
  logic        resultValid_r;
  logic [DATA_W-1:0] resultData_r;
  logic        calValueLoad_r;
  logic        active_r;

  // stop-mode pin is asynchronous: three flops, act when last two are both high
  logic [2:0]  stopSync_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        wrAcc    = psel && penable && pwrite;
  wire        selCtrl  = paddr == adc_cal_avg_pkg::CTRL_OFFSET;
  wire        selOfs   = paddr == adc_cal_avg_pkg::OFS_OFFSET;
  wire        selTrig  = paddr == adc_cal_avg_pkg::TRIG_OFFSET;
  wire        selRes   = paddr == adc_cal_avg_pkg::RESULT_OFFSET;
  wire        selCal   = paddr == adc_cal_avg_pkg::CALVAL_OFFSET;
  wire        mapped   = selCtrl || selOfs || selTrig || selRes || selCal;
  wire        wrCtrl   = wrAcc && selCtrl;
  wire        wrOfs    = wrAcc && selOfs;
  wire        wrTrig   = wrAcc && selTrig;
  wire        calGo    = wrCtrl && pwdata[adc_cal_avg_pkg::CAL_BIT] && !cal_r;
  wire        inCal    = state_r == adc_cal_avg_pkg::ST_CAL;
  wire        calDone  = inCal && calCnt_r == 6'(adc_cal_avg_pkg::CAL_CYCLES - 1);
  // a stop request counts once the second and third flops are both high
  wire        stopNow  = stopSync_r[2] && stopSync_r[1];
  // failure causes while calibrating
  wire        calBad   = inCal && (wrAcc || trig_r || stopNow);
  wire        calEnd   = calDone || calBad;

  // ----------------------------------------------------------------
  // averaging and correction
  // ----------------------------------------------------------------
  function automatic logic [5:0] sampleCount(input logic en, input logic [1:0] sel);
    sampleCount = en ? (6'h04 << sel) : 6'h01;
  endfunction : sampleCount

  function automatic logic [DATA_W-1:0] correct(input logic [DATA_W-1:0] raw, input logic [15:0] ofs,
                                                  input logic [DATA_W-1:0] hi, input logic [DATA_W-1:0] lo);
    logic signed [DATA_W+16:0] diff;
    diff = $signed({17'h0, raw}) - $signed({{(DATA_W+1){ofs[15]}}, ofs});
    if (diff > $signed({17'h0, hi}))
      correct = hi;
    else if (diff < $signed({17'h0, lo}))
      correct = lo;
    else
      correct = diff[DATA_W-1:0];
  endfunction : correct

  wire [5:0]  setSize  = sampleCount(mode_r.avgEn, mode_r.avgSel);
  wire [20:0] accNext  = accum_r + 21'(sampleData);
  wire        lastSamp = sampleValid && state_r == adc_cal_avg_pkg::ST_CONV && sampCnt_r == setSize - 6'h01;
  // mean by shift: sample counts are powers of two
  wire [20:0] mean     = mode_r.avgEn ? (accNext >> (3'd2 + 3'(mode_r.avgSel))) : accNext;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      adc_cal_avg_pkg::ST_IDLE: begin
        if (calGo)
          state_nxt = adc_cal_avg_pkg::ST_CAL;
        else if (convStart)
          state_nxt = adc_cal_avg_pkg::ST_CONV;
      end
      adc_cal_avg_pkg::ST_CONV: begin
        if (calGo)
          state_nxt = adc_cal_avg_pkg::ST_CAL;
        else if (lastSamp && !mode_r.cont)
          state_nxt = adc_cal_avg_pkg::ST_IDLE;
      end
      adc_cal_avg_pkg::ST_CAL: begin
        if (calEnd)
          state_nxt = adc_cal_avg_pkg::ST_IDLE;
      end
      default: state_nxt = adc_cal_avg_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_r    <= adc_cal_avg_pkg::ST_IDLE;
      stopSync_r <= 3'h0;
    end else begin
      state_r    <= state_nxt;
      stopSync_r <= {stopSync_r[1:0], stopMode};
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_r    <= '0;
      cal_r     <= 1'b0;
      calFail_r <= 1'b0;
      trig_r    <= 1'b0;
    end else begin
      if (wrCtrl && !inCal)
        mode_r <= {pwdata[adc_cal_avg_pkg::CONT_BIT], pwdata[adc_cal_avg_pkg::AVERAGE_ENABLE_BIT], pwdata[1:0]};
      if (calGo)
        cal_r <= 1'b1;
      else if (calEnd)
        cal_r <= 1'b0;
      // failure set wins over the clearing write
      if (calBad)
        calFail_r <= 1'b1;
      else if (calGo)
        calFail_r <= 1'b0;
      else if (wrCtrl)
        calFail_r <= 1'b0;
      if (wrTrig && !inCal)
        trig_r <= pwdata[adc_cal_avg_pkg::TRIG_BIT];
    end
  end

  // ----------------------------------------------------------------
  // offset register and calibration counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ofs_r          <= adc_cal_avg_pkg::OFS_RESET;
      calCnt_r       <= 6'h00;
      calValueLoad_r <= 1'b0;
    end else begin
      calValueLoad_r <= calDone && !calBad;
      calCnt_r       <= inCal ? calCnt_r + 6'h01 : 6'h00;
      if (calDone && !calBad)
        ofs_r <= calOffset;
      else if (wrOfs && !inCal)
        ofs_r <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sampCnt_r     <= 6'h00;
      accum_r       <= 21'h0;
      active_r      <= 1'b0;
      convRequest_r <= 1'b0;
      convAbort_r   <= 1'b0;
      resultValid_r <= 1'b0;
      resultData_r  <= '0;
    end else begin
      convAbort_r   <= calGo && state_r == adc_cal_avg_pkg::ST_CONV;
      resultValid_r <= lastSamp && !calGo;
      convRequest_r <= state_nxt == adc_cal_avg_pkg::ST_CONV;
      active_r      <= state_nxt == adc_cal_avg_pkg::ST_CONV;
      if (state_r != adc_cal_avg_pkg::ST_CONV || calGo) begin
        sampCnt_r <= 6'h00;
        accum_r   <= 21'h0;
      end else if (lastSamp) begin
        sampCnt_r    <= 6'h00;
        accum_r      <= 21'h0;
        resultData_r <= correct(mean[DATA_W-1:0], ofs_r, modeMax, modeMin);
      end else if (sampleValid) begin
        sampCnt_r <= sampCnt_r + 6'h01;
        accum_r   <= accNext;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [31:0] ctrlRead = {24'h0, cal_r, calFail_r, 2'b00, mode_r.cont, mode_r.avgEn, mode_r.avgSel};
  assign prdata = !psel ? 32'h0 :
                  selCtrl ? ctrlRead :
                  selOfs ? {16'h0, ofs_r} :
                  selTrig ? {30'h0, active_r, trig_r} :
                  selRes ? 32'(resultData_r) :
                  selCal ? {31'h0, calValueLoad_r} : 32'h0;
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !mapped;
  assign convRequest  = convRequest_r;
  assign convAbort    = convAbort_r;
  assign resultValid  = resultValid_r;
  assign resultData   = resultData_r;
  assign calValueLoad = calValueLoad_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_cal_start_sets: assert property (@(posedge clk_sys) disable iff (!rstn)
    calGo |=> cal_r && inCal) else $error("calibration did not start");
  a_cal_bit_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
    inCal |-> cal_r) else $error("calibration bit low while calibrating");
  a_write_fails_cal: assert property (@(posedge clk_sys) disable iff (!rstn)
    inCal && wrAcc |=> calFail_r && !cal_r) else $error("write did not fail calibration");
  a_abort_conv: assert property (@(posedge clk_sys) disable iff (!rstn)
    calGo && state_r == adc_cal_avg_pkg::ST_CONV |=> convAbort && !active_r) else $error("conversion not aborted");
  a_trig_fails_cal: assert property (@(posedge clk_sys) disable iff (!rstn)
    inCal && trig_r |=> calFail_r) else $error("hardware trigger did not fail calibration");
  a_write_clears_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    wrCtrl && !calBad && calFail_r |=> !calFail_r) else $error("flag not cleared by write");
  a_single_stops: assert property (@(posedge clk_sys) disable iff (!rstn)
    lastSamp && !mode_r.cont && !calGo |=> state_r == adc_cal_avg_pkg::ST_IDLE) else $error("single run kept going");
  a_result_clamped: assert property (@(posedge clk_sys) disable iff (!rstn)
    resultValid && $stable(modeMax) |-> resultData <= modeMax) else $error("result above limit");
  a_cal_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    calDone && !calBad |=> calValueLoad && ofs_r == $past(calOffset)) else $error("calibration values not loaded");

  // ----------------------------------------------------------------
  // checks: calibration
  // ----------------------------------------------------------------
  a_stop_fails_cal: assert property (@(posedge clk_sys) disable iff (!rstn)
    inCal && stopNow |=> calFail_r && !inCal)
    else $error("stop request did not fail calibration");

  a_cal_end_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
    calEnd |=> !cal_r && state_r == adc_cal_avg_pkg::ST_IDLE)
    else $error("calibration bit not cleared at end");

  a_cal_success: assert property (@(posedge clk_sys) disable iff (!rstn)
    calDone && !calBad |=> !calFail_r)
    else $error("failed flag set after clean calibration");

  a_mode_frozen: assert property (@(posedge clk_sys) disable iff (!rstn)
    inCal && wrCtrl |=> mode_r == $past(mode_r))
    else $error("mode changed by write during calibration");

  a_calload_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    calValueLoad |=> !calValueLoad)
    else $error("calibration load pulse too long");

  a_abort_only_cal: assert property (@(posedge clk_sys) disable iff (!rstn)
    convAbort |-> $past(calGo) && $past(state_r) == adc_cal_avg_pkg::ST_CONV)
    else $error("abort without calibration start");

  // ----------------------------------------------------------------
  // checks: conversion
  // ----------------------------------------------------------------
  a_result_floor: assert property (@(posedge clk_sys) disable iff (!rstn)
    resultValid && $stable(modeMin) |-> resultData >= modeMin)
    else $error("result below limit");

  a_active_start: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_r == adc_cal_avg_pkg::ST_IDLE && convStart && !calGo |=> active_r && convRequest)
    else $error("run start not flagged active");

  a_cont_repeats: assert property (@(posedge clk_sys) disable iff (!rstn)
    lastSamp && mode_r.cont && !calGo |=> state_r == adc_cal_avg_pkg::ST_CONV && active_r)
    else $error("continuous run stopped");

  a_single_size: assert property (@(posedge clk_sys) disable iff (!rstn)
    !mode_r.avgEn |-> setSize == 6'h01)
    else $error("set size not one without averaging");

  a_set_size: assert property (@(posedge clk_sys) disable iff (!rstn)
    mode_r.avgEn |-> (mode_r.avgSel == 2'h0 && setSize == 6'h04) ||
                     (mode_r.avgSel == 2'h1 && setSize == 6'h08) ||
                     (mode_r.avgSel == 2'h2 && setSize == 6'h10) ||
                     (mode_r.avgSel == 2'h3 && setSize == 6'h20))
    else $error("set size does not match select");

  // ----------------------------------------------------------------
  // checks: register bus
  // ----------------------------------------------------------------
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    psel && selCtrl |-> prdata[31:8] == 24'h0 && prdata[5:4] == 2'h0)
    else $error("reserved control bits not zero");

  a_ofs_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    wrOfs && !inCal |=> ofs_r == $past(pwdata[15:0]))
    else $error("offset write not stored");

  a_trig_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    wrTrig && !inCal |=> trig_r == $past(pwdata[adc_cal_avg_pkg::TRIG_BIT]))
    else $error("trigger select write not stored");
endmodule : adc_cal_avg
`default_nettype wire

//--- adc_cal_avg_test.sv
// testbench: registers, averaging, offset correction and calibration of the block
`default_nettype none
module adc_cal_avg_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdq;
  logic        convStart, sampleValid, stopMode, convRequest, convAbort, resultValid, calValueLoad, errq;
  logic [15:0] sampleData, modeMax, modeMin, calOffset, resultData, ofsModel;
  logic        abortSeen = 1'b0;
  int          errTotal, testsRun, k;
  logic [15:0] baseTab [4] = '{16'h0100, 16'h0F00, 16'h0010, 16'h0800};
  logic [15:0] ofsTab  [4] = '{16'h0010, 16'hFF00, 16'h0100, 16'h0000};
  adc_cal_avg i_adc_cal_avg (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .convStart(convStart),
    .sampleValid(sampleValid), .sampleData(sampleData), .modeMax(modeMax), .modeMin(modeMin),
    .stopMode(stopMode), .calOffset(calOffset), .convRequest(convRequest), .convAbort(convAbort),
    .resultValid(resultValid), .resultData(resultData), .calValueLoad(calValueLoad));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // abort is a one-cycle pulse: keep a sticky copy for the sequence to compare
  always @(posedge clk_sys) begin
    if (convAbort === 1'b1) abortSeen <= 1'b1;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task report_and_stop;
    if (errTotal == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // request held until pready is seen high at a rising edge; answer taken at that edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
    if (w && a == adc_cal_avg_pkg::OFS_OFFSET) ofsModel = d[15:0];
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk("read", rdq, exp);
  endtask : rd
  task conv(input int n, input logic [15:0] base, input logic start);
    int sum, s, m;
    sum = 0;
    if (start) begin
      convStart <= 1'b1;
      @(posedge clk_sys);
      convStart <= 1'b0;
    end
    for (int i = 0; i < n; i++) begin
      s = base + $urandom % 256;
      sampleValid <= 1'b1;
      sampleData <= s[15:0];
      sum += s;
      @(posedge clk_sys);
    end
    sampleValid <= 1'b0;
    m = sum / n - int'($signed(ofsModel));
    if (m > int'(modeMax)) m = modeMax;
    if (m < int'(modeMin)) m = modeMin;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (resultValid !== 1'b1 && k < 20);
    chk("valid", {31'h0, resultValid}, 32'h0000_0001);
    chk("result", {16'h0000, resultData}, m[31:0]);
    @(posedge clk_sys);
  endtask : conv
  initial begin
    repeat (20000) @(posedge clk_sys);
    errTotal++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, psel, penable, pwrite, convStart, sampleValid, stopMode} = 7'h00;
    {paddr, pwdata, sampleData, ofsModel} = '0;
    modeMax = 16'h0FFF;
    modeMin = 16'h0004;
    errTotal = 0;
    testsRun = 0;
    k = $urandom(32'h21C3);
    calOffset = 16'($urandom);
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0000);
    rd(adc_cal_avg_pkg::OFS_OFFSET, 32'h0000_0000);
    apb(1'b1, adc_cal_avg_pkg::CTRL_OFFSET, 32'hFFFF_FF3F);
    rd(adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_000F);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("slverr", {31'h0, errq}, 32'h0000_0001);
    apb(1'b1, adc_cal_avg_pkg::TRIG_OFFSET, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, adc_cal_avg_pkg::OFS_OFFSET, {16'h0000, ofsTab[s]});
      apb(1'b1, adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0004 | s);
      conv(4 << s, baseTab[s], 1'b1);
    end
    apb(1'b1, adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0000);
    conv(1, 16'h0200, 1'b1);
    rd(adc_cal_avg_pkg::TRIG_OFFSET, 32'h0000_0000);
    chk("request", {31'h0, convRequest}, 32'h0000_0000);
    apb(1'b1, adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_000C);
    conv(4, 16'h0300, 1'b1);
    conv(4, 16'h0400, 1'b0);
    rd(adc_cal_avg_pkg::TRIG_OFFSET, 32'h0000_0002);
    chk("request", {31'h0, convRequest}, 32'h0000_0001);
    // calibration start must kill the running set
    apb(1'b1, adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0080);
    rd(adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0080);
    chk("abort", {31'h0, abortSeen}, 32'h0000_0001);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (calValueLoad !== 1'b1 && k < 100);
    chk("calload", {31'h0, calValueLoad}, 32'h0000_0001);
    @(posedge clk_sys);
    rd(adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0000);
    rd(adc_cal_avg_pkg::OFS_OFFSET, {16'h0000, calOffset});
    rd(adc_cal_avg_pkg::TRIG_OFFSET, 32'h0000_0000);
    apb(1'b1, adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0080);
    apb(1'b1, adc_cal_avg_pkg::OFS_OFFSET, 32'h0000_1234);
    rd(adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0040);
    apb(1'b1, adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0000);
    rd(adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0000);
    apb(1'b1, adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0080);
    stopMode <= 1'b1;
    repeat (6) @(posedge clk_sys);
    stopMode <= 1'b0;
    rd(adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0040);
    apb(1'b1, adc_cal_avg_pkg::TRIG_OFFSET, 32'h0000_0001);
    apb(1'b1, adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0080);
    repeat (3) @(posedge clk_sys);
    rd(adc_cal_avg_pkg::CTRL_OFFSET, 32'h0000_0040);
    report_and_stop();
  end
endmodule : adc_cal_avg_test
`default_nettype wire
